// File: dhci_cfg.svh
`ifndef DHCI_CFG_SVH
`define DHCI_CFG_SVH

// register word addresses on the avalon slave
`define DHCI_OFS_GROUP_CTRL   16'h0A02
`define DHCI_OFS_DBG_STATUS   16'h0A06
`define DHCI_OFS_DBG_IRQ_EN   16'h0A08
`define DHCI_OFS_HC_STATUS    16'h0A0A
`define DHCI_OFS_HC_IRQ_EN    16'h0A0C
`define DHCI_OFS_TIMEOUT_CTRL 16'h0A0E

// reset values
`define DHCI_RST_REG          16'h0000
`define DHCI_RST_RDATA        32'h0000_0000

// debug group bit positions
`define DHCI_BIT_WBUF_OVF     0
`define DHCI_BIT_DISP_UNDER   1

// group enable bit positions in the group control register
`define DHCI_BIT_GRP_DBG      4'h0
`define DHCI_BIT_GRP_HOST     4'h4

// host cycle group bit positions
`define DHCI_BIT_HC_JF_WR     1
`define DHCI_BIT_HC_LB_RD     2
`define DHCI_BIT_HC_LB_WR     3
`define DHCI_BIT_HC_BT_RD     4
`define DHCI_BIT_HC_BT_WR     5
`define DHCI_BIT_HC_TIMEOUT   15

// timeout control fields
`define DHCI_TO_VALUE_W       5
`define DHCI_TO_COUNT_W       6
`define DHCI_BIT_TO_IMM_TERM  7

// implemented bits of each register
`define DHCI_MASK_GROUP       16'h0011
`define DHCI_MASK_DBG         16'h0003
`define DHCI_MASK_HC          16'h803E
`define DHCI_MASK_TO          16'h009F

`endif

// File: dhci_pkg.sv
`include "dhci_cfg.svh"

package dhci_pkg;

    typedef struct packed {
        logic [15:0] grp_ctrl;
        logic [15:0] dbg_status;
        logic [15:0] dbg_en;
        logic [15:0] hc_status;
        logic [15:0] hc_en;
        logic [15:0] to_ctrl;
        logic        ack;
        logic [31:0] rdata;
        logic        irq;
    } dhci_state_t;

    typedef struct packed {
        logic [`DHCI_TO_COUNT_W-1:0] count;
        logic                        fired;
        logic                        pulse;
    } dhci_to_state_t;

    // sticky flag update: a set in the same cycle as a clear wins
    function automatic logic [15:0] dhci_w1c(input logic [15:0] cur,
                                             input logic [15:0] set,
                                             input logic [15:0] clr);
        return set | (cur & ~clr);
    endfunction

    // read/write register merge under byte lanes and implemented bits
    function automatic logic [15:0] dhci_merge(input logic [15:0] cur,
                                               input logic [15:0] wd,
                                               input logic [15:0] lanes,
                                               input logic [15:0] mask);
        return ((cur & ~lanes) | (wd & lanes)) & mask;
    endfunction

endpackage

// File: dhci_timeout.sv
`include "dhci_cfg.svh"

module dhci_timeout
    import dhci_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic                        access_active,
    input  wire logic [`DHCI_TO_VALUE_W-1:0] timeout_value,
    output logic                             timeout_pulse
);
    import dhci_pkg::*;

    dhci_to_state_t s_reg;
    dhci_to_state_t s_next;

    always_comb begin
        s_next       = s_reg;
        s_next.pulse = 1'b0;
        if (!access_active) begin
            s_next.count = '0;
            s_next.fired = 1'b0;
        end else if (!s_reg.fired) begin
            // one pulse per access once the count passes the programmed value
            if (s_reg.count > {1'b0, timeout_value}) begin
                s_next.pulse = 1'b1;
                s_next.fired = 1'b1;
            end else begin
                s_next.count = s_reg.count + `DHCI_TO_COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign timeout_pulse = s_reg.pulse;

endmodule

// File: dhci_top.sv
// Contract
// R1: set underrun flag on fetch from empty FIFO
// R2: underrun irq needs local and debug enables
// R3: writing one clears underrun, zero ignored
// R4: set overflow flag on write-buffer overflow
// R5: writing one clears overflow, zero ignored
// R6: overflow local enable gates its irq
// R7: set timeout status when access exceeds value
// R8: timeout irq needs raw, local, host enables
// R9: host cycle status bits clear on one
// R10: full line-buffer write terminated, status set
// R11: terminate irqs need local and host enables
// R12: empty line-buffer read terminated, status set
// R13: full jpeg FIFO write terminated, status set
// R14: bitmap FIFO terminated write sets bit 5
// R15: bitmap FIFO terminated read sets bit 4
// R16: host retries access after terminate irq
// R17: host status bit 0 reads zero
// R18: group control bit 0 enables debug group
// R19: group control bit 4 enables host group
// R20: raw status ignores enables; irq is OR
`include "dhci_cfg.svh"

module dhci_top
    import dhci_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input  wire logic                mclk,
    input  wire logic                reset_n,
    // avalon-mm slave, word addressed
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // debug group events
    input  wire logic                panel_fetch,
    input  wire logic                disp_fifo_empty,
    input  wire logic                wbuf_overflow,
    // jpeg fifo host writes
    input  wire logic                jpeg_fifo_wr_req,
    input  wire logic                jpeg_fifo_full,
    output logic                     jpeg_fifo_wr_accept,
    // jpeg line buffer host accesses
    input  wire logic                jpeg_lb_wr_req,
    input  wire logic                jpeg_lb_full,
    output logic                     jpeg_lb_wr_accept,
    input  wire logic                jpeg_lb_rd_req,
    input  wire logic                jpeg_lb_empty,
    output logic                     jpeg_lb_rd_accept,
    // bitmap-transfer fifo terminate events
    input  wire logic                bt_fifo_wr_term,
    input  wire logic                bt_fifo_rd_term,
    // host access to any of the three targets in progress
    input  wire logic                host_access_active,
    // timeout setting for the host interface
    output logic                     imm_term_en,
    // interrupt to the host processor, active high
    output logic                     host_int
);
    import dhci_pkg::*;

    dhci_state_t s_reg;
    dhci_state_t s_next;

    logic        timeout_pulse;
    logic [15:0] ev_dbg;
    logic [15:0] ev_hc;
    logic [15:0] lanes;
    logic [15:0] wdata;
    logic        wr_fire;
    logic        rd_take;
    logic        jf_wr_term;
    logic        lb_wr_term;
    logic        lb_rd_term;
    logic        dbg_pending;
    logic        hc_pending;
    logic        pend_ovf;
    logic        pend_under;
    logic        pend_timeout;
    logic        pend_bt_wr;
    logic        pend_bt_rd;
    logic        pend_lb_wr;
    logic        pend_lb_rd;
    logic        pend_jf_wr;
    logic [5:0]  reg_sel;

    // one-hot register select, shared by the write and the read path
    function automatic logic [5:0] reg_select(input logic [ADDR_W-1:0] addr);
        logic [5:0] sel;
        sel    = 6'h00;
        sel[0] = (addr == ADDR_W'(`DHCI_OFS_GROUP_CTRL));
        sel[1] = (addr == ADDR_W'(`DHCI_OFS_DBG_STATUS));
        sel[2] = (addr == ADDR_W'(`DHCI_OFS_DBG_IRQ_EN));
        sel[3] = (addr == ADDR_W'(`DHCI_OFS_HC_STATUS));
        sel[4] = (addr == ADDR_W'(`DHCI_OFS_HC_IRQ_EN));
        sel[5] = (addr == ADDR_W'(`DHCI_OFS_TIMEOUT_CTRL));
        return sel;
    endfunction

    dhci_timeout u_timeout (
        .mclk          (mclk),
        .reset_n       (reset_n),
        .access_active (host_access_active),
        .timeout_value (s_reg.to_ctrl[`DHCI_TO_VALUE_W-1:0]),
        .timeout_pulse (timeout_pulse)
    );

    // terminated cycles: the access is dropped, nothing stored or returned
    assign jf_wr_term          = jpeg_fifo_wr_req & jpeg_fifo_full;   // R13
    assign lb_wr_term          = jpeg_lb_wr_req & jpeg_lb_full;       // R10
    assign lb_rd_term          = jpeg_lb_rd_req & jpeg_lb_empty;      // R12
    assign jpeg_fifo_wr_accept = jpeg_fifo_wr_req & ~jpeg_fifo_full;  // R13
    assign jpeg_lb_wr_accept   = jpeg_lb_wr_req & ~jpeg_lb_full;      // R10
    assign jpeg_lb_rd_accept   = jpeg_lb_rd_req & ~jpeg_lb_empty;     // R12

    // event vectors aligned to their status bit positions
    always_comb begin
        ev_dbg                        = 16'h0000;
        ev_dbg[`DHCI_BIT_DISP_UNDER]  = panel_fetch & disp_fifo_empty;  // R1
        ev_dbg[`DHCI_BIT_WBUF_OVF]    = wbuf_overflow;                  // R4
        ev_hc                         = 16'h0000;
        ev_hc[`DHCI_BIT_HC_TIMEOUT]   = timeout_pulse;                  // R7
        ev_hc[`DHCI_BIT_HC_BT_WR]     = bt_fifo_wr_term;                // R14
        ev_hc[`DHCI_BIT_HC_BT_RD]     = bt_fifo_rd_term;                // R15
        ev_hc[`DHCI_BIT_HC_LB_WR]     = lb_wr_term;                     // R10
        ev_hc[`DHCI_BIT_HC_LB_RD]     = lb_rd_term;                     // R12
        ev_hc[`DHCI_BIT_HC_JF_WR]     = jf_wr_term;                     // R13
    end

    // one wait state: write taken at the edge where waitrequest is low, read data latched in the wait cycle
    assign wr_fire         = avs_write & s_reg.ack;
    assign rd_take         = avs_read & ~s_reg.ack;
    assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.ack;

    assign lanes = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata = avs_writedata[15:0];
    assign reg_sel = reg_select(avs_address);

    always_comb begin
        s_next     = s_reg;
        s_next.ack = (avs_read | avs_write) & ~s_reg.ack;

        // status bits are set by events whatever the enables say
        s_next.dbg_status = dhci_w1c(s_reg.dbg_status, ev_dbg, 16'h0000);  // R20
        s_next.hc_status  = dhci_w1c(s_reg.hc_status, ev_hc, 16'h0000);    // R20

        if (wr_fire) begin
            unique case (1'b1)
                reg_sel[0]: begin
                    s_next.grp_ctrl = dhci_merge(s_reg.grp_ctrl, wdata, lanes,
                                                 `DHCI_MASK_GROUP);
                end
                reg_sel[1]: begin
                    // ones clear, zeros leave the flag alone
                    s_next.dbg_status = dhci_w1c(s_reg.dbg_status, ev_dbg,
                                                 wdata & lanes);  // R3 R5
                end
                reg_sel[2]: begin
                    s_next.dbg_en = dhci_merge(s_reg.dbg_en, wdata, lanes,
                                               `DHCI_MASK_DBG);
                end
                reg_sel[3]: begin
                    s_next.hc_status = dhci_w1c(s_reg.hc_status, ev_hc,
                                                wdata & lanes);  // R9
                end
                reg_sel[4]: begin
                    s_next.hc_en = dhci_merge(s_reg.hc_en, wdata, lanes,
                                              `DHCI_MASK_HC);
                end
                reg_sel[5]: begin
                    s_next.to_ctrl = dhci_merge(s_reg.to_ctrl, wdata, lanes,
                                                `DHCI_MASK_TO);
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end

        s_next.dbg_status = s_next.dbg_status & `DHCI_MASK_DBG;
        s_next.hc_status  = s_next.hc_status & `DHCI_MASK_HC;  // R17

        // read data captured in the wait cycle and held through the answer
        if (rd_take) begin
            unique case (1'b1)
                reg_sel[0]: begin
                    s_next.rdata = {16'h0000, s_reg.grp_ctrl};
                end
                reg_sel[1]: begin
                    s_next.rdata = {16'h0000, s_reg.dbg_status};
                end
                reg_sel[2]: begin
                    s_next.rdata = {16'h0000, s_reg.dbg_en};
                end
                reg_sel[3]: begin
                    s_next.rdata = {16'h0000, s_reg.hc_status};  // R17
                end
                reg_sel[4]: begin
                    s_next.rdata = {16'h0000, s_reg.hc_en};
                end
                reg_sel[5]: begin
                    s_next.rdata = {16'h0000, s_reg.to_ctrl};
                end
                default: begin
                    s_next.rdata = `DHCI_RST_RDATA;
                end
            endcase
        end

        // each source gated by its own enable, from next state so host_int
        // moves at the same edge as the status it reflects
        pend_ovf     = s_next.dbg_status[`DHCI_BIT_WBUF_OVF]
                       & s_next.dbg_en[`DHCI_BIT_WBUF_OVF];      // R6
        pend_under   = s_next.dbg_status[`DHCI_BIT_DISP_UNDER]
                       & s_next.dbg_en[`DHCI_BIT_DISP_UNDER];    // R2
        pend_timeout = s_next.hc_status[`DHCI_BIT_HC_TIMEOUT]
                       & s_next.hc_en[`DHCI_BIT_HC_TIMEOUT];     // R8
        pend_bt_wr   = s_next.hc_status[`DHCI_BIT_HC_BT_WR]
                       & s_next.hc_en[`DHCI_BIT_HC_BT_WR];       // R11
        pend_bt_rd   = s_next.hc_status[`DHCI_BIT_HC_BT_RD]
                       & s_next.hc_en[`DHCI_BIT_HC_BT_RD];       // R11
        pend_lb_wr   = s_next.hc_status[`DHCI_BIT_HC_LB_WR]
                       & s_next.hc_en[`DHCI_BIT_HC_LB_WR];       // R11
        pend_lb_rd   = s_next.hc_status[`DHCI_BIT_HC_LB_RD]
                       & s_next.hc_en[`DHCI_BIT_HC_LB_RD];       // R11
        pend_jf_wr   = s_next.hc_status[`DHCI_BIT_HC_JF_WR]
                       & s_next.hc_en[`DHCI_BIT_HC_JF_WR];       // R11

        // group enables gate each group as a whole
        dbg_pending  = (pend_ovf | pend_under)
                       & s_next.grp_ctrl[`DHCI_BIT_GRP_DBG];     // R18
        hc_pending   = (pend_timeout | pend_bt_wr | pend_bt_rd | pend_lb_wr
                        | pend_lb_rd | pend_jf_wr)
                       & s_next.grp_ctrl[`DHCI_BIT_GRP_HOST];    // R19
        s_next.irq   = dbg_pending | hc_pending;                 // R20
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.grp_ctrl   <= `DHCI_RST_REG;
            s_reg.dbg_status <= `DHCI_RST_REG;
            s_reg.dbg_en     <= `DHCI_RST_REG;
            s_reg.hc_status  <= `DHCI_RST_REG;
            s_reg.hc_en      <= `DHCI_RST_REG;
            s_reg.to_ctrl    <= `DHCI_RST_REG;
            s_reg.ack        <= 1'b0;
            s_reg.rdata      <= `DHCI_RST_RDATA;
            s_reg.irq        <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata = s_reg.rdata;
    assign imm_term_en  = s_reg.to_ctrl[`DHCI_BIT_TO_IMM_TERM];
    assign host_int     = s_reg.irq;

endmodule

// File: dhci_host_model.sv
module dhci_host_model (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic retry_go,
    input  wire logic wr_accept,
    output logic      wr_req
);
    timeunit 1ns;
    timeprecision 100ps;
    // host keeps re-issuing a terminated write until it is taken
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) wr_req <= 1'b0;
        else if (retry_go) wr_req <= 1'b1;
        else if (wr_accept) wr_req <= 1'b0;
    end
endmodule

// File: dhci_chk.sv
module dhci_chk (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        panel_fetch,
    input wire logic        disp_fifo_empty,
    input wire logic        wbuf_overflow,
    input wire logic        jpeg_fifo_wr_req,
    input wire logic        jpeg_fifo_full,
    input wire logic        jpeg_fifo_wr_accept,
    input wire logic        jpeg_lb_wr_req,
    input wire logic        jpeg_lb_full,
    input wire logic        jpeg_lb_wr_accept,
    input wire logic        jpeg_lb_rd_req,
    input wire logic        jpeg_lb_empty,
    input wire logic        jpeg_lb_rd_accept,
    input wire logic        bt_fifo_wr_term,
    input wire logic        bt_fifo_rd_term,
    input wire logic        host_access_active,
    input wire logic        host_int
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic ev_any;
    assign ev_any = panel_fetch & disp_fifo_empty | wbuf_overflow | bt_fifo_wr_term
        | jpeg_fifo_wr_req & jpeg_fifo_full | jpeg_lb_wr_req & jpeg_lb_full
        | jpeg_lb_rd_req & jpeg_lb_empty | bt_fifo_rd_term;
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("more than one wait cycle");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("stall without request");
    a_rdata_stands: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without a read");
    a_jf_term: assert property (jpeg_fifo_wr_accept == (jpeg_fifo_wr_req &&
        !jpeg_fifo_full)) else $error("jpeg fifo accept wrong");
    a_lb_wr_term: assert property (jpeg_lb_wr_accept == (jpeg_lb_wr_req &&
        !jpeg_lb_full)) else $error("line buffer write accept wrong");
    a_lb_rd_term: assert property (jpeg_lb_rd_accept == (jpeg_lb_rd_req &&
        !jpeg_lb_empty)) else $error("line buffer read accept wrong");
    a_int_cause: assert property ($rose(host_int) |-> $past(ev_any) || $past(avs_write)
        || $past(host_access_active, 2)) else $error("interrupt without cause");
    a_int_clear: assert property ($fell(host_int) |-> $past(avs_write)
        && !$past(avs_waitrequest)) else $error("interrupt dropped without write");
    cover property ($rose(host_int));
    cover property (jpeg_lb_rd_req && jpeg_lb_empty);
    cover property (avs_read && !avs_waitrequest);
endmodule

// File: dhci_top_tb.sv
`include "dhci_cfg.svh"
module dhci_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, reset_n, rd, wr, pf, dfe, wo, jff, lbwr, lbf, lbrd, lbe, btw, btr;
    logic        haa, go, wq, jfreq, jfacc, lbwa, lbra, imm, hint;
    logic [15:0] adr, rv;
    logic [31:0] wd, rdat;
    logic [3:0]  be;
    logic [15:0] m [6];
    int          n_mismatch, check_count;
    localparam logic [15:0] OFS [6] = '{`DHCI_OFS_GROUP_CTRL, `DHCI_OFS_DBG_STATUS,
        `DHCI_OFS_DBG_IRQ_EN, `DHCI_OFS_HC_STATUS, `DHCI_OFS_HC_IRQ_EN, `DHCI_OFS_TIMEOUT_CTRL};
    localparam logic [15:0] MSK [6] = '{16'h0011, 16'h0003, 16'h0003, 16'h803E, 16'h803E,
        16'h009F};
    localparam int IDX [7] = '{1, 1, 3, 3, 3, 3, 3};
    localparam int BITP [7] = '{0, 1, 1, 3, 2, 4, 5};
    dhci_top u_dhci_top (.mclk(mclk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wq), .panel_fetch(pf), .disp_fifo_empty(dfe), .wbuf_overflow(wo),
        .jpeg_fifo_wr_req(jfreq), .jpeg_fifo_full(jff), .jpeg_fifo_wr_accept(jfacc),
        .jpeg_lb_wr_req(lbwr), .jpeg_lb_full(lbf), .jpeg_lb_wr_accept(lbwa),
        .jpeg_lb_rd_req(lbrd), .jpeg_lb_empty(lbe), .jpeg_lb_rd_accept(lbra),
        .bt_fifo_wr_term(btw), .bt_fifo_rd_term(btr), .host_access_active(haa),
        .imm_term_en(imm), .host_int(hint));
    dhci_host_model u_dhci_host_model (.mclk(mclk), .reset_n(reset_n), .retry_go(go),
        .wr_accept(jfacc), .wr_req(jfreq));
    function automatic logic exp_int();
        return (|(m[1] & m[2]) & m[0][0]) | (|(m[3] & m[4]) & m[0][4]);
    endfunction
    task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        int k;
        @(posedge mclk);
        adr <= a;
        wd <= {16'h0000, d};
        wr <= w;
        rd <= !w;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (wq !== 1'b0 && k < 50);
        rv = rdat[15:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (k >= 50) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic wreg(input int i, input logic [15:0] d);
        bus(1'b1, OFS[i], d);
        if (i == 1 || i == 3) m[i] = m[i] & ~(d & MSK[i]);
        else m[i] = d & MSK[i];
    endtask
    task automatic chk(input int i);
        bus(1'b0, OFS[i], 16'h0000);
        cmp_reg(rv, m[i]);
    endtask
    task automatic chk_int();
        @(negedge mclk);
        cmp_pin(hint, exp_int());
    endtask
    task automatic ev(input int s);
        @(posedge mclk);
        case (s)
            0: wo <= 1'b1;
            1: begin pf <= 1'b1; dfe <= 1'b1; end
            2: begin go <= 1'b1; jff <= 1'b1; end
            3: begin lbwr <= 1'b1; lbf <= 1'b1; end
            4: begin lbrd <= 1'b1; lbe <= 1'b1; end
            5: btr <= 1'b1;
            default: btw <= 1'b1;
        endcase
        @(posedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        cmp_pin(jfacc, 1'b0);
        cmp_pin(lbwa, 1'b0);
        cmp_pin(lbra, 1'b0);
        @(posedge mclk);
        {wo, pf, dfe, jff, lbwr, lbf, lbrd, lbe, btr, btw} <= '0;
        @(negedge mclk);
        cmp_pin(jfacc, s == 2);
        m[IDX[s]][BITP[s]] = 1'b1;
        repeat (3) @(posedge mclk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {reset_n, rd, wr, pf, dfe, wo, jff, lbwr, lbf, lbrd, lbe, btw, btr, haa, go} = '0;
        adr = '0;
        wd = '0;
        be = 4'h3;
        foreach (m[i]) m[i] = 16'h0000;
        void'($urandom(32'h2ba8));
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) chk(i);
        bus(1'b0, 16'h0A10, 16'h0000);
        cmp_reg(rv, 16'h0000);
        $display("test reset values done");
        repeat (3) for (int i = 0; i < 6; i++) begin
            wreg(i, 16'($urandom()));
            chk(i);
            cmp_pin(imm, m[5][7]);
        end
        $display("test register access done");
        @(posedge mclk) {lbwr, lbrd} <= 2'b11;
        @(negedge mclk);
        cmp_pin(lbwa, 1'b1);
        cmp_pin(lbra, 1'b1);
        @(posedge mclk) {lbwr, lbrd} <= 2'b00;
        chk(3);
        wreg(0, 16'h0011);
        wreg(2, 16'h0003);
        wreg(4, 16'hFFFF);
        for (int s = 0; s < 7; s++) begin
            ev(s);
            chk_int();
            chk(IDX[s]);
            wreg(IDX[s], ~(16'h0001 << BITP[s]));
            chk(IDX[s]);
            wreg(0, 16'h0000);
            chk_int();
            wreg(0, 16'h0011);
            wreg(IDX[s] + 1, 16'h0000);
            chk_int();
            wreg(IDX[s] + 1, MSK[IDX[s]]);
            wreg(IDX[s], 16'h0001 << BITP[s]);
            chk(IDX[s]);
            chk_int();
        end
        $display("test event sources done");
        wreg(5, 16'h0003);
        @(posedge mclk) haa <= 1'b1;
        repeat (2) @(posedge mclk);
        haa <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(3);
        @(posedge mclk) haa <= 1'b1;
        repeat (12) @(posedge mclk);
        haa <= 1'b0;
        m[3][15] = 1'b1;
        chk(3);
        chk_int();
        wreg(3, 16'h8000);
        chk(3);
        $display("test cycle timeout done");
        report_and_stop();
    end
endmodule
bind dhci_top dhci_chk u_dhci_chk (.mclk(mclk), .reset_n(reset_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .panel_fetch(panel_fetch), .disp_fifo_empty(disp_fifo_empty),
    .wbuf_overflow(wbuf_overflow), .jpeg_fifo_wr_req(jpeg_fifo_wr_req),
    .jpeg_fifo_full(jpeg_fifo_full), .jpeg_fifo_wr_accept(jpeg_fifo_wr_accept),
    .jpeg_lb_wr_req(jpeg_lb_wr_req), .jpeg_lb_full(jpeg_lb_full),
    .jpeg_lb_wr_accept(jpeg_lb_wr_accept), .jpeg_lb_rd_req(jpeg_lb_rd_req),
    .jpeg_lb_empty(jpeg_lb_empty), .jpeg_lb_rd_accept(jpeg_lb_rd_accept),
    .bt_fifo_wr_term(bt_fifo_wr_term), .bt_fifo_rd_term(bt_fifo_rd_term),
    .host_access_active(host_access_active), .host_int(host_int));
